/* rtl/ata_feat_max.sv */
/*
 * Task-file command engine for set-features and max-address commands,
 * with its task registers reached over AXI4-Lite.
 * Assumes the password logic supplies the lock and freeze levels on this
 * clock; the reassignment-full and hardware-reset inputs are pins.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Unknown feature selector code aborts the set-features command.
// - 02h/82h switch write cache; full reassignment forces it off.
// - 55h turns read look-ahead off, AAh turns it on.
// - 44h selects 52 ECC bytes for long transfers, BBh selects 4.
// - 05h sets power level: 80-BFh idle, 40-7Fh low-RPM, others abort.
// - 85h disables advanced power management.
// - 42h/C2h switch acoustic management; level C0-FEh normal, 80-BFh quiet.
// - Acoustic settings survive power-on, hardware and software resets.
// - 06h/86h switch power-up-in-standby; 07h requests spin-up.
// - 09h enters address-offset operation, 89h leaves it.
// - 66h/CCh switch reverting to defaults; 5Dh/DDh switch release interrupt.
// - Power-on and hardware reset restore documented feature defaults.
// - For 03h sector count splits into transfer type and mode.
// - Legal types: default PIO, flow PIO 0-4, MDMA 0-2, UDMA 0-5.
// - Max-address after read-native sets maximum; else selector picks subcommand.
// - New maximum within capacity; later accesses beyond it are flagged.
// - Second nonvolatile setting aborts until power-on or hardware reset.
// - Max-address after read-native aborts while protection is locked or frozen.
// - Persistence bit keeps maximum over power-on; with offset mode aborts.
// - LBA form takes sector number and cylinders; CHS ignores sector number.
// - Head field gives address bits 24-27 in LBA form.
// - Completion returns the set maximum in the task registers.
module ata_feat_max (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [5:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        hard_reset_n,
   input  wire logic        reassign_full,
   input  wire logic        prot_locked,
   input  wire logic        prot_frozen,
   input  wire logic        access_valid,
   input  wire logic [27:0] access_lba,
   output logic             access_beyond,
   output logic             write_cache_on,
   output logic             read_ahead_on,
   output logic             ecc_long_52,
   output logic             apm_on,
   output logic             apm_low_rpm,
   output logic             aam_on,
   output logic             aam_quiet,
   output logic             standby_powerup_on,
   output logic             spinup_req,
   output logic             offset_mode_on,
   output logic             release_int_on,
   output logic             revert_defaults_on,
   output logic [4:0]       xfer_type,
   output logic [2:0]       xfer_mode,
   output logic [3:0]       setmax_sub,
   output logic [27:0]      max_address
);
   import ata_feat_pkg::*;

   typedef struct packed {
      logic        awready, wready, arready, aw_got, w_got, bvalid, rvalid;
      logic [5:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [1:0]  bresp, rresp;
      logic [31:0] rdata;
      logic [7:0]  feat, scnt, snum, cyl_lo, cyl_hi, devhd, cmd, err, stat;
      logic        exec, after_native;
      logic [2:0]  hrst_sync, full_sync;
      logic        hrst_act, full_act;
      logic        wc, rla, ecc52, revert, relint, apm, apm_lowrpm, aam, aam_quiet;
      logic        puis, spinup, offset;
      logic [4:0]  xtype;
      logic [2:0]  xmode;
      logic [3:0]  sub;
      logic [27:0] maxa, nv_maxa;
      logic        nv_valid, nv_done, beyond;
   } state_s;

   state_s s_q;
   state_s s_d;

   function automatic logic feat_defined(input logic [7:0] f);
      case (f)
         F_WC_ON, F_XFER, F_APM_ON, F_PUIS_ON, F_SPINUP, F_OFS_ON, F_AAM_ON, F_ECC52,
         F_RLA_OFF, F_REL_ON, F_REV_OFF, F_WC_OFF, F_APM_OFF, F_PUIS_OFF, F_OFS_OFF,
         F_RLA_ON, F_ECC4, F_AAM_OFF, F_REV_ON, F_REL_OFF: feat_defined = 1'b1;
         default: feat_defined = 1'b0;
      endcase
   endfunction

   function automatic logic xfer_ok(input logic [7:0] sc);
      case (sc[7:3])
         XT_PIO_DEF:  xfer_ok = sc[2:0] <= XM_PIO_DEF_MAX;
         XT_PIO_FLOW: xfer_ok = sc[2:0] <= XM_PIO_MAX;
         XT_MDMA:     xfer_ok = sc[2:0] <= XM_MDMA_MAX;
         XT_UDMA:     xfer_ok = sc[2:0] <= XM_UDMA_MAX;
         default:     xfer_ok = 1'b0;
      endcase
   endfunction

   // Feature defaults; acoustic fields are left alone on purpose
   function automatic state_s feat_defaults(input state_s s);
      state_s r;
      r = s;
      r.wc = ata_feat_pkg::RST_WC;
      r.ecc52 = ata_feat_pkg::RST_ECC52;
      r.rla = ata_feat_pkg::RST_RLA;
      r.revert = ata_feat_pkg::RST_REVERT;
      r.relint = ata_feat_pkg::RST_RELINT;
      r.apm = 1'b0;
      r.apm_lowrpm = 1'b0;
      r.xtype = ata_feat_pkg::XT_PIO_DEF;
      r.xmode = 3'h0;
      r.after_native = 1'b0;
      feat_defaults = r;
   endfunction

   logic [27:0] req_max;
   logic        abort;

   always_comb
   begin
      s_d = s_q;
      abort = 1'b0;
      req_max = s_q.devhd[6] ? {s_q.devhd[3:0], s_q.cyl_hi, s_q.cyl_lo, s_q.snum}
                             : {s_q.devhd[3:0], s_q.cyl_hi, s_q.cyl_lo, CHS_MAX_SECTOR};
      s_d.spinup = 1'b0;
      s_d.sub = 4'h0;
      s_d.exec = 1'b0;
      s_d.beyond = access_valid && (access_lba > s_q.maxa);
      // Pins pass three stages; a level counts once the last two agree
      s_d.hrst_sync = {s_q.hrst_sync[1:0], hard_reset_n};
      s_d.full_sync = {s_q.full_sync[1:0], reassign_full};
      if (s_q.hrst_sync[2] == s_q.hrst_sync[1])
         s_d.hrst_act = ~s_q.hrst_sync[2];
      if (s_q.full_sync[2] == s_q.full_sync[1])
         s_d.full_act = s_q.full_sync[2];

      if (awvalid && s_q.awready)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = awaddr;
      end
      if (wvalid && s_q.wready)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = wdata;
         s_d.wstrb = wstrb;
      end
      if (bready && s_q.bvalid)
         s_d.bvalid = 1'b0;
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         // Parameter writes during busy are dropped, not queued
         if (s_q.wstrb[0] && !s_q.stat[ST_BSY])
            case (s_q.awaddr)
               A_FEAT_ERR: s_d.feat = s_q.wdata[7:0];
               A_SCNT:     s_d.scnt = s_q.wdata[7:0];
               A_SNUM:     s_d.snum = s_q.wdata[7:0];
               A_CYL_LO:   s_d.cyl_lo = s_q.wdata[7:0];
               A_CYL_HI:   s_d.cyl_hi = s_q.wdata[7:0];
               A_DEVHD:    s_d.devhd = s_q.wdata[7:0];
               A_CMD_STAT:
               begin
                  s_d.cmd = s_q.wdata[7:0];
                  s_d.exec = 1'b1;
                  s_d.stat = STAT_BUSY;
                  s_d.err = 8'h00;
               end
               default: ;
            endcase
         if (s_q.awaddr > A_MAX || s_q.awaddr[1:0] != 2'h0)
            s_d.bresp = RESP_SLVERR;
      end

      if (rready && s_q.rvalid)
         s_d.rvalid = 1'b0;
      if (arvalid && s_q.arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         case (araddr)
            A_FEAT_ERR: s_d.rdata = {24'h0, s_q.err};
            A_SCNT:     s_d.rdata = {24'h0, s_q.scnt};
            A_SNUM:     s_d.rdata = {24'h0, s_q.snum};
            A_CYL_LO:   s_d.rdata = {24'h0, s_q.cyl_lo};
            A_CYL_HI:   s_d.rdata = {24'h0, s_q.cyl_hi};
            A_DEVHD:    s_d.rdata = {24'h0, s_q.devhd};
            A_CMD_STAT: s_d.rdata = {24'h0, s_q.stat};
            A_CTRL:     s_d.rdata = 32'h0;
            A_STATE:    s_d.rdata = {10'h0, s_q.nv_valid, s_q.nv_done, s_q.after_native,
                                     s_q.offset, s_q.puis, s_q.aam_quiet, s_q.aam,
                                     s_q.apm_lowrpm, s_q.apm, s_q.relint, s_q.revert,
                                     s_q.ecc52, s_q.rla, s_q.wc, s_q.xtype, s_q.xmode};
            A_MAX:      s_d.rdata = {4'h0, s_q.maxa};
            default:
            begin
               s_d.rdata = 32'h0;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end

      if (s_q.exec)
      begin
         s_d.after_native = 1'b0;
         case (s_q.cmd)
            CMD_SET_FEAT:
               case (s_q.feat)
                  F_WC_ON:    s_d.wc = !s_q.full_act;
                  F_WC_OFF:   s_d.wc = 1'b0;
                  F_RLA_OFF:  s_d.rla = 1'b0;
                  F_RLA_ON:   s_d.rla = 1'b1;
                  F_ECC52:    s_d.ecc52 = 1'b1;
                  F_ECC4:     s_d.ecc52 = 1'b0;
                  F_XFER:
                     if (xfer_ok(s_q.scnt))
                     begin
                        s_d.xtype = s_q.scnt[7:3];
                        s_d.xmode = s_q.scnt[2:0];
                     end
                     else
                        abort = 1'b1;
                  F_APM_ON:
                     if (s_q.scnt >= APM_MIN && s_q.scnt <= APM_MAX)
                     begin
                        s_d.apm = 1'b1;
                        s_d.apm_lowrpm = s_q.scnt < APM_IDLE_MIN;
                     end
                     else
                        abort = 1'b1;
                  F_APM_OFF:  s_d.apm = 1'b0;
                  F_AAM_ON:
                     if (s_q.scnt >= AAM_MIN && s_q.scnt <= AAM_MAX)
                     begin
                        s_d.aam = 1'b1;
                        s_d.aam_quiet = s_q.scnt < AAM_NORMAL_MIN;
                     end
                     else
                        abort = 1'b1;
                  F_AAM_OFF:  s_d.aam = 1'b0;
                  F_PUIS_ON:  s_d.puis = 1'b1;
                  F_PUIS_OFF: s_d.puis = 1'b0;
                  F_SPINUP:   s_d.spinup = 1'b1;
                  F_OFS_ON:   s_d.offset = 1'b1;
                  F_OFS_OFF:  s_d.offset = 1'b0;
                  F_REV_OFF:  s_d.revert = 1'b0;
                  F_REV_ON:   s_d.revert = 1'b1;
                  F_REL_ON:   s_d.relint = 1'b1;
                  F_REL_OFF:  s_d.relint = 1'b0;
                  default:    abort = 1'b1;
               endcase
            CMD_READ_NATIVE:
            begin
               s_d.after_native = 1'b1;
               {s_d.devhd[3:0], s_d.cyl_hi, s_d.cyl_lo, s_d.snum} = NATIVE_MAX;
            end
            CMD_SET_MAX:
               if (!s_q.after_native)
               begin
                  if (s_q.feat >= SUB_SET_PW && s_q.feat <= SUB_FREEZE)
                     s_d.sub[s_q.feat[1:0] - 2'h1] = 1'b1;
                  else
                     abort = 1'b1;
               end
               else if (prot_locked || prot_frozen)
                  abort = 1'b1;
               else if (s_q.scnt[0] && (s_q.offset || s_q.nv_done))
                  abort = 1'b1;
               else if (req_max > NATIVE_MAX)
                  abort = 1'b1;
               else
               begin
                  s_d.maxa = req_max;
                  if (s_q.scnt[0])
                  begin
                     s_d.nv_maxa = req_max;
                     s_d.nv_valid = 1'b1;
                     s_d.nv_done = 1'b1;
                  end
                  s_d.snum = s_q.devhd[6] ? req_max[7:0] : CHS_MAX_SECTOR;
               end
            default: abort = 1'b1;
         endcase
         s_d.err = abort ? ERR_ABT_MASK : 8'h00;
         s_d.stat = abort ? (STAT_DONE | STAT_ERR) : STAT_DONE;
      end

      // Control writes model a power cycle and a soft reset of the drive
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.awaddr == A_CTRL && s_q.wstrb[0])
      begin
         if (s_q.wdata[CTRL_POWER_ON])
         begin
            s_d = feat_defaults(s_d);
            s_d.maxa = s_q.nv_valid ? s_q.nv_maxa : NATIVE_MAX;
            s_d.nv_done = 1'b0;
         end
         else if (s_q.wdata[CTRL_SOFT_RST] && s_q.revert)
            s_d = feat_defaults(s_d);
      end
      if (s_q.hrst_act)
      begin
         s_d = feat_defaults(s_d);
         s_d.nv_done = 1'b0;
      end

      // Reassignment overflow wins over any enable or reset default
      if (s_q.full_act)
         s_d.wc = 1'b0;

      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.hrst_sync <= 3'h7;
         s_q.wc <= RST_WC;
         s_q.rla <= RST_RLA;
         s_q.ecc52 <= RST_ECC52;
         s_q.revert <= RST_REVERT;
         s_q.relint <= RST_RELINT;
         s_q.stat <= STAT_DONE;
         s_q.maxa <= NATIVE_MAX;
         s_q.nv_maxa <= NATIVE_MAX;
      end
      else
         s_q <= s_d;
   end

   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign access_beyond = s_q.beyond;
   assign write_cache_on = s_q.wc;
   assign read_ahead_on = s_q.rla;
   assign ecc_long_52 = s_q.ecc52;
   assign apm_on = s_q.apm;
   assign apm_low_rpm = s_q.apm_lowrpm;
   assign aam_on = s_q.aam;
   assign aam_quiet = s_q.aam_quiet;
   assign standby_powerup_on = s_q.puis;
   assign spinup_req = s_q.spinup;
   assign offset_mode_on = s_q.offset;
   assign release_int_on = s_q.relint;
   assign revert_defaults_on = s_q.revert;
   assign xfer_type = s_q.xtype;
   assign xfer_mode = s_q.xmode;
   assign setmax_sub = s_q.sub;
   assign max_address = s_q.maxa;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_undef_abort;
      s_q.exec && s_q.cmd == CMD_SET_FEAT && !feat_defined(s_q.feat) |=> s_q.err[ERR_ABT];
   endproperty
   a_undef_abort: assert property (p_undef_abort) else $error("undefined feature not aborted");

   property p_wc_forced;
      s_q.full_act |=> !write_cache_on;
   endproperty
   a_wc_forced: assert property (p_wc_forced) else $error("write cache on while full");

   property p_rla_off;
      s_q.exec && s_q.cmd == CMD_SET_FEAT && s_q.feat == F_RLA_OFF && !s_q.hrst_act
      |=> !read_ahead_on && !s_q.err[ERR_ABT];
   endproperty
   a_rla_off: assert property (p_rla_off) else $error("look-ahead not disabled");

   property p_apm_abort;
      s_q.exec && s_q.cmd == CMD_SET_FEAT && s_q.feat == F_APM_ON
      && (s_q.scnt < APM_MIN || s_q.scnt > APM_MAX) |=> s_q.err[ERR_ABT] && $stable(apm_low_rpm);
   endproperty
   a_apm_abort: assert property (p_apm_abort) else $error("bad power level accepted");

   property p_aam_hold;
      s_q.hrst_act |=> $stable(aam_on) && $stable(aam_quiet);
   endproperty
   a_aam_hold: assert property (p_aam_hold) else $error("acoustic lost on reset");

   property p_nv_second;
      s_q.exec && s_q.cmd == CMD_SET_MAX && s_q.after_native && s_q.scnt[0] && s_q.nv_done
      |=> s_q.err[ERR_ABT] && $stable(max_address);
   endproperty
   a_nv_second: assert property (p_nv_second) else $error("second nonvolatile set taken");

   property p_locked;
      s_q.exec && s_q.cmd == CMD_SET_MAX && s_q.after_native && (prot_locked || prot_frozen)
      |=> s_q.err[ERR_ABT] && s_q.stat[0];
   endproperty
   a_locked: assert property (p_locked) else $error("max set while locked");

   property p_done;
      s_q.exec |-> s_q.stat[ST_BSY] ##1 (!s_q.stat[ST_BSY] && s_q.stat[6]
                   && s_q.stat[0] == s_q.err[ERR_ABT]);
   endproperty
   a_done: assert property (p_done) else $error("bad completion status");
endmodule
`default_nettype wire

/* shared/ata_feat_pkg.sv */
/*
 * Constants for the set-features and max-address command block:
 * register byte offsets, task-file codes, bit positions, reset values.
 * Assumes a 32-bit AXI4-Lite slave port with byte-addressed words.
 */
`default_nettype none
package ata_feat_pkg;
   localparam int          ADDR_W         = 6;
   localparam logic [5:0]  A_FEAT_ERR     = 6'h00;
   localparam logic [5:0]  A_SCNT         = 6'h04;
   localparam logic [5:0]  A_SNUM         = 6'h08;
   localparam logic [5:0]  A_CYL_LO       = 6'h0c;
   localparam logic [5:0]  A_CYL_HI       = 6'h10;
   localparam logic [5:0]  A_DEVHD        = 6'h14;
   localparam logic [5:0]  A_CMD_STAT     = 6'h18;
   localparam logic [5:0]  A_CTRL         = 6'h1c;
   localparam logic [5:0]  A_STATE        = 6'h20;
   localparam logic [5:0]  A_MAX          = 6'h24;
   localparam int          CTRL_SOFT_RST  = 0;
   localparam int          CTRL_POWER_ON  = 1;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [7:0]  CMD_SET_FEAT   = 8'hef;
   localparam logic [7:0]  CMD_SET_MAX    = 8'hf9;
   localparam logic [7:0]  CMD_READ_NATIVE = 8'hf8;
   localparam logic [7:0]  F_WC_ON        = 8'h02;
   localparam logic [7:0]  F_XFER         = 8'h03;
   localparam logic [7:0]  F_APM_ON       = 8'h05;
   localparam logic [7:0]  F_PUIS_ON      = 8'h06;
   localparam logic [7:0]  F_SPINUP       = 8'h07;
   localparam logic [7:0]  F_OFS_ON       = 8'h09;
   localparam logic [7:0]  F_AAM_ON       = 8'h42;
   localparam logic [7:0]  F_ECC52        = 8'h44;
   localparam logic [7:0]  F_RLA_OFF      = 8'h55;
   localparam logic [7:0]  F_REL_ON       = 8'h5d;
   localparam logic [7:0]  F_REV_OFF      = 8'h66;
   localparam logic [7:0]  F_WC_OFF       = 8'h82;
   localparam logic [7:0]  F_APM_OFF      = 8'h85;
   localparam logic [7:0]  F_PUIS_OFF     = 8'h86;
   localparam logic [7:0]  F_OFS_OFF      = 8'h89;
   localparam logic [7:0]  F_RLA_ON       = 8'haa;
   localparam logic [7:0]  F_ECC4         = 8'hbb;
   localparam logic [7:0]  F_AAM_OFF      = 8'hc2;
   localparam logic [7:0]  F_REV_ON       = 8'hcc;
   localparam logic [7:0]  F_REL_OFF      = 8'hdd;
   localparam logic [7:0]  SUB_SET_PW     = 8'h01;
   localparam logic [7:0]  SUB_FREEZE     = 8'h04;
   localparam logic [7:0]  APM_MIN        = 8'h40;
   localparam logic [7:0]  APM_IDLE_MIN   = 8'h80;
   localparam logic [7:0]  APM_MAX        = 8'hbf;
   localparam logic [7:0]  AAM_MIN        = 8'h80;
   localparam logic [7:0]  AAM_NORMAL_MIN = 8'hc0;
   localparam logic [7:0]  AAM_MAX        = 8'hfe;
   localparam logic [4:0]  XT_PIO_DEF     = 5'h00;
   localparam logic [4:0]  XT_PIO_FLOW    = 5'h01;
   localparam logic [4:0]  XT_MDMA        = 5'h04;
   localparam logic [4:0]  XT_UDMA        = 5'h08;
   localparam logic [2:0]  XM_PIO_DEF_MAX = 3'h1;
   localparam logic [2:0]  XM_PIO_MAX     = 3'h4;
   localparam logic [2:0]  XM_MDMA_MAX    = 3'h2;
   localparam logic [2:0]  XM_UDMA_MAX    = 3'h5;
   localparam int          ERR_ABT        = 2;
   localparam int          ST_BSY         = 7;
   localparam logic [7:0]  STAT_BUSY      = 8'h80;
   localparam logic [7:0]  STAT_DONE      = 8'h50;
   localparam logic [7:0]  STAT_ERR       = 8'h01;
   localparam logic [7:0]  ERR_ABT_MASK   = 8'h04;
   localparam logic        RST_WC         = 1'b1;
   localparam logic        RST_ECC52      = 1'b0;
   localparam logic        RST_RLA        = 1'b1;
   localparam logic        RST_REVERT     = 1'b0;
   localparam logic        RST_RELINT     = 1'b0;
   localparam logic [27:0] NATIVE_MAX     = 28'h0ff_ffff;
   localparam logic [7:0]  CHS_MAX_SECTOR = 8'h3f;
endpackage
`default_nettype wire

/* testbench/host_adapter.sv */
/* Host adapter model: AXI4-Lite master that loads the task registers.
   Assumes one clock shared with the command block; answers never stall. */
`timescale 1ns/1ps
`default_nettype none
module host_adapter (
   input  wire logic        aclk,
   output logic [5:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [5:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready,
   output logic             hang
);
   // Ready held high so no response is ever refused
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid, hang} = '0;
      bready = 1'b1;
      rready = 1'b1;
   end
   // Caller orders parameter writes before the opcode
   task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      awaddr  <= a;
      wdata   <= {24'h0, v};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (r === 2'h3 && n < 64)
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
            r = bresp;
      end
      if (r === 2'h3)
         hang <= 1'b1;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      araddr  <= a;
      arvalid <= 1'b1;
      while (r === 2'h3 && n < 64)
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            r = rresp;
            v = rdata;
         end
      end
      if (r === 2'h3)
         hang <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
/* Self-checking bench for the set-features and max-address engine.
   Assumes host_adapter drives the register bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
   logic        arready, rvalid, rready, hard_reset_n, reassign_full, prot_locked, hang;
   logic        prot_frozen, access_valid, access_beyond, write_cache_on, read_ahead_on;
   logic        ecc_long_52, apm_on, apm_low_rpm, aam_on, aam_quiet, standby_powerup_on;
   logic        spinup_req, offset_mode_on, release_int_on, revert_defaults_on, spun;
   logic [1:0]  bresp, rresp, r;
   logic [3:0]  wstrb, setmax_sub, sub_seen;
   logic [4:0]  xfer_type;
   logic [2:0]  xfer_mode;
   logic [5:0]  awaddr, araddr;
   logic [7:0]  ex;
   logic [27:0] access_lba, max_address;
   logic [31:0] wdata, rdata, d;
   int          failures = 0;
   int          checks_done = 0;
   wire logic [10:0] feat = {write_cache_on, read_ahead_on, ecc_long_52, apm_on, apm_low_rpm,
      aam_on, aam_quiet, standby_powerup_on, offset_mode_on, release_int_on, revert_defaults_on};
   // Entry: code, sector count, abort bit 12, expected feature levels
   logic [31:0] tbl [35] = '{32'h82000200, 32'h02000600, 32'h55000400, 32'haa000600,
      32'h44000700, 32'hbb000600, 32'h054006c0, 32'h05c016c0, 32'h05800680, 32'h85000600,
      32'h053f1600, 32'h42800630, 32'h42ff1630, 32'h42c00620, 32'h427f1620, 32'h06000628,
      32'h07000628, 32'h86000620, 32'h09000624, 32'h5d000626, 32'hcc000627, 32'h66000626,
      32'hdd000624, 32'h89000620, 32'h01001620, 32'h03010620, 32'h030c0620, 32'h030d1620,
      32'h03220620, 32'h03231620, 32'h03451620 & 32'hffffefff, 32'h03461620, 32'h03101620,
      32'h03021620, 32'h82000220};
   ata_feat_max i_ata_feat_max (.*);
   host_adapter i_host_adapter (.*);
   always #5 aclk = ~aclk;
   // Pulses are one cycle wide, so they are collected as sticky flags
   always @(posedge aclk)
   begin
      spun <= aresetn && (spun || spinup_req);
      sub_seen <= aresetn ? (sub_seen | setmax_sub) : 4'h0;
   end
   always @(posedge hang)
   begin
      failures++;
      results();
   end
   task automatic results;
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic stat(input logic a);
      logic [1:0]  q;
      logic [31:0] v;
      i_host_adapter.rd(ata_feat_pkg::A_CMD_STAT, v, q);
      `CHK(v, a ? 32'h51 : 32'h50)
      i_host_adapter.rd(ata_feat_pkg::A_FEAT_ERR, v, q);
      `CHK(v, a ? 32'h04 : 32'h00)
   endtask
   task automatic cmd(input logic [7:0] f, input logic [7:0] s, input logic a);
      logic [1:0] q;
      i_host_adapter.wr(ata_feat_pkg::A_FEAT_ERR, f, q);
      i_host_adapter.wr(ata_feat_pkg::A_SCNT, s, q);
      i_host_adapter.wr(ata_feat_pkg::A_CMD_STAT, 8'hef, q);
      stat(a);
   endtask
   task automatic sm(input logic [7:0] s, input logic [7:0] c, input logic [7:0] dh, input logic a);
      logic [1:0] q;
      i_host_adapter.wr(6'h18, 8'hf8, q);
      i_host_adapter.wr(6'h04, s, q);
      i_host_adapter.wr(6'h08, 8'h34, q);
      i_host_adapter.wr(6'h0c, c, q);
      i_host_adapter.wr(6'h10, 8'h00, q);
      i_host_adapter.wr(6'h14, dh, q);
      i_host_adapter.wr(6'h18, 8'hf9, q);
      stat(a);
   endtask
   initial
   begin
      {aclk, aresetn, reassign_full, prot_locked, prot_frozen, access_valid, spun} = '0;
      {hard_reset_n, access_lba, sub_seen, ex} = {1'b1, 28'h0, 4'h0, 8'h00};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      i_host_adapter.rd(6'h20, d, r);
      `CHK(d, 32'h300)
      i_host_adapter.rd(6'h24, d, r);
      `CHK(d[27:0], ata_feat_pkg::NATIVE_MAX)
      i_host_adapter.rd(6'h28, d, r);
      `CHK(r, ata_feat_pkg::RESP_SLVERR)
      foreach (tbl[i])
      begin
         cmd(tbl[i][31:24], tbl[i][23:16], tbl[i][12]);
         if (tbl[i][31:24] == 8'h03 && !tbl[i][12])
            ex = tbl[i][23:16];
         `CHK(feat, tbl[i][10:0])
         `CHK({xfer_type, xfer_mode}, ex)
      end
      `CHK(spun, 1'b1)
      reassign_full <= 1'b1;
      cmd(8'h02, 8'h00, 1'b0);
      `CHK(write_cache_on, 1'b0)
      reassign_full <= 1'b0;
      sm(8'h00, 8'h12, 8'h40, 1'b0);
      i_host_adapter.rd(6'h24, d, r);
      `CHK(d, 32'h1234)
      i_host_adapter.rd(6'h08, d, r);
      `CHK(d, 32'h34)
      access_valid <= 1'b1;
      access_lba <= 28'h1235;
      @(posedge aclk);
      access_lba <= 28'h1234;
      @(posedge aclk);
      `CHK(access_beyond, 1'b1)
      @(posedge aclk);
      `CHK(access_beyond, 1'b0)
      sm(8'h00, 8'h05, 8'ha0, 1'b0);
      i_host_adapter.rd(6'h24, d, r);
      `CHK(d, 32'h53f)
      sm(8'h00, 8'h12, 8'h41, 1'b1);
      cmd(8'h09, 8'h00, 1'b0);
      sm(8'h01, 8'h12, 8'h40, 1'b1);
      cmd(8'h89, 8'h00, 1'b0);
      sm(8'h01, 8'h12, 8'h40, 1'b0);
      sm(8'h01, 8'h12, 8'h40, 1'b1);
      prot_locked <= 1'b1;
      sm(8'h00, 8'h12, 8'h40, 1'b1);
      {prot_locked, prot_frozen} <= 2'b01;
      sm(8'h00, 8'h12, 8'h40, 1'b1);
      prot_frozen <= 1'b0;
      i_host_adapter.wr(6'h00, 8'h02, r);
      i_host_adapter.wr(6'h18, 8'hf9, r);
      stat(1'b0);
      `CHK(sub_seen, 4'b0010)
      i_host_adapter.wr(6'h1c, 8'h02, r);
      @(posedge aclk);
      `CHK(feat, 11'h620)
      `CHK(max_address, 28'h1234)
      cmd(8'h82, 8'h00, 1'b0);
      i_host_adapter.wr(6'h1c, 8'h01, r);
      @(posedge aclk);
      `CHK(feat, 11'h220)
      hard_reset_n <= 1'b0;
      repeat (6) @(posedge aclk);
      hard_reset_n <= 1'b1;
      repeat (6) @(posedge aclk);
      `CHK(feat, 11'h620)
      results();
   end
endmodule
`default_nettype wire
